// [verification/host_model.sv]
module host_model
(
  // Request from the bench
  input wire logic pwr_want_i,
  // Pins toward the chip
  output logic reg_on_o,
  output logic lpo_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Always-on slow oscillator, free running and unrelated to the main clock
  initial
  begin
    lpo_clk_o = 1'b0;
    forever #15258.789 lpo_clk_o = ~lpo_clk_o;
  end

  // Only this host request ever lifts the chip out of power-down
  assign reg_on_o = pwr_want_i;
endmodule

// [verification/power_mode_sequencer_tb.sv]
module power_mode_sequencer_tb import power_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SLOW = 763; // Main clock cycles per slow tick
  logic mclk_i, rst_n_i, pwr_want, reg_on, lpo_clk, wake_ext, usb_res;
  logic busy, save_done, restore_done, core_rst_n, save_req, restore_req;
  logic [1:0] mode_req, clk_sel;
  logic [15:0] wake_ticks;
  logic [N_RES-1:0] min_res, act_mask, res_en, act_set;
  logic [N_RES-1:0][N_RES-1:0] dep;
  logic [N_RES-1:0][7:0] t_on, t_off;
  logic [2:0] mode, last_mode;
  logic [CAL_W-1:0] cal;
  int num_errors = 0;
  int check_count = 0;
  int seed = 32'h8503;
  int n, ticks;
  mode_t exp_q[$];

  ////////////////////////////////////////////////////////////////////////////
  host_model host_model_i (.pwr_want_i(pwr_want), .reg_on_o(reg_on),
    .lpo_clk_o(lpo_clk));
  power_mode_sequencer power_mode_sequencer_i (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .reg_on_i(reg_on), .lpo_clk_i(lpo_clk),
    .wake_ext_i(wake_ext), .usb_resume_i(usb_res), .mode_req_i(mode_req),
    .busy_i(busy), .save_done_i(save_done), .restore_done_i(restore_done),
    .wake_ticks_i(wake_ticks), .min_res_i(min_res), .act_mask_i(act_mask),
    .dep_i(dep), .t_on_i(t_on), .t_off_i(t_off), .res_en_o(res_en),
    .mode_o(mode), .core_rst_n_o(core_rst_n), .clk_sel_o(clk_sel),
    .save_req_o(save_req), .restore_req_o(restore_req),
    .cal_period_o(cal));

  ////////////////////////////////////////////////////////////////////////////
  // Main clock
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // Core load flips at random so both clock speeds get exercised
  always @(posedge mclk_i)
    busy <= #2 1'($random(seed));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cmp_mode(input logic [2:0] got, input logic [2:0] exp);
    report({29'h0, got}, {29'h0, exp});
  endtask

  task automatic cmp_res(input logic [7:0] got, input logic [7:0] exp);
    report({24'h0, got}, {24'h0, exp});
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    report({31'h0, got}, {31'h0, exp});
  endtask

  task automatic cmp_clk(input logic [1:0] got, input logic [1:0] exp);
    report({30'h0, got}, {30'h0, exp});
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #2;
  endtask

  // Bounded waits: a value that never shows up is a mismatch
  task automatic wait_mode(input mode_t m);
    n = 0;
    while (mode !== m && n < 8000)
    begin
      step(1);
      n++;
    end
    cmp_mode(mode, m);
  endtask

  task automatic wait_res(input logic [7:0] e);
    n = 0;
    while (res_en !== e && n < 4000)
    begin
      step(1);
      n++;
    end
    cmp_res(res_en, e);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference model of the mode sequence: every change must be the next one
  always @(posedge mclk_i)
  begin
    #1;
    if (rst_n_i === 1'b1 && mode !== last_mode)
    begin
      if (exp_q.size() == 0)
        cmp_mode(mode, last_mode);
      else
        cmp_mode(mode, exp_q.pop_front());
    end
    last_mode = mode;
    // Load seen at this edge picks the active clock speed
    if (mode === M_ACTIVE)
      cmp_clk(clk_sel, busy === 1'b1 ? CLK_FAST : CLK_SLOW);
    if (res_en[RES_RADIO] === 1'b1)
      cmp_bit(res_en[RES_XTAL], 1'b1);
  end

  // Hang guard, well beyond the expected run time
  initial
  begin
    #1600000;
    num_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n_i = 1'b0;
    pwr_want = 1'b0;
    wake_ext = 1'b0;
    usb_res = 1'b0;
    mode_req = REQ_ACTIVE;
    save_done = 1'b0;
    restore_done = 1'b0;
    wake_ticks = 16'h0000;
    last_mode = M_OFF;
    min_res = 8'h01;
    act_mask = 8'hF7;
    dep = '0;
    dep[RES_RADIO][RES_XTAL] = 1'b1;
    dep[RES_CORE][RES_CSW] = 1'b1;
    dep[RES_CLIN][RES_CSW] = 1'b1;
    t_on = '0;
    t_off = '0;
    t_on[RES_RADIO] = 8'h02;
    t_off[RES_ANALOG] = 8'h01;
    act_set = act_mask | min_res | SET_LPL;
    step(20);
    rst_n_i = 1'b1;
    step(4);
    cmp_mode(mode, M_OFF);
    cmp_res(res_en, SET_NONE);
    cmp_bit(core_rst_n, 1'b0);
    // Power-up, with one timed resource
    exp_q = {M_BOOT, M_ACTIVE};
    pwr_want = 1'b1;
    wait_mode(M_BOOT);
    n = 0;
    while (res_en[RES_RADIO] !== 1'b1 && n < 4000)
    begin
      step(1);
      n++;
    end
    cmp_bit(n >= SLOW - 4 && n <= 2 * SLOW + 8, 1'b1);
    wait_mode(M_ACTIVE);
    cmp_res(res_en, act_set);
    cmp_bit(core_rst_n, 1'b1);
    cmp_bit(clk_sel !== CLK_GATED, 1'b1);
    step(2 * SLOW);
    cmp_bit(cal >= LPO_CYC - 1 && cal <= LPO_CYC + 2, 1'b1);
    // A one-cycle dip of the request must be filtered out
    pwr_want = 1'b0;
    step(1);
    pwr_want = 1'b1;
    step(10);
    cmp_mode(mode, M_ACTIVE);
    // Doze and external wake
    exp_q = {M_DOZE, M_WAKE, M_ACTIVE};
    mode_req = REQ_DOZE;
    wait_mode(M_DOZE);
    mode_req = REQ_ACTIVE;
    wait_res(SET_DOZE | min_res);
    cmp_bit(clk_sel === CLK_GATED, 1'b1);
    step(50);
    wake_ext = 1'b1;
    wait_mode(M_ACTIVE);
    wake_ext = 1'b0;
    cmp_res(res_en, act_set);
    // Deep sleep with save, USB wake and restore
    exp_q = {M_SAVE, M_DEEP, M_WAKE, M_RESTORE, M_ACTIVE};
    mode_req = REQ_DEEP;
    wait_mode(M_SAVE);
    mode_req = REQ_ACTIVE;
    cmp_bit(save_req, 1'b1);
    step(5);
    cmp_mode(mode, M_SAVE);
    save_done = 1'b1;
    wait_mode(M_DEEP);
    save_done = 1'b0;
    cmp_bit(save_req, 1'b0);
    wait_res(SET_DEEP);
    cmp_bit(core_rst_n, 1'b0);
    cmp_bit(clk_sel === CLK_GATED, 1'b1);
    usb_res = 1'b1;
    wait_mode(M_RESTORE);
    usb_res = 1'b0;
    cmp_bit(restore_req, 1'b1);
    cmp_res(res_en, act_set);
    step(3);
    restore_done = 1'b1;
    wait_mode(M_ACTIVE);
    restore_done = 1'b0;
    // Deep sleep ended by the slow wake timer
    ticks = 2 + ($unsigned($random(seed)) % 3);
    wake_ticks = 16'(ticks);
    exp_q = {M_SAVE, M_DEEP, M_WAKE, M_RESTORE, M_ACTIVE};
    mode_req = REQ_DEEP;
    wait_mode(M_SAVE);
    mode_req = REQ_ACTIVE;
    save_done = 1'b1;
    wait_mode(M_DEEP);
    save_done = 1'b0;
    n = 0;
    while (mode === M_DEEP && n < 8000)
    begin
      step(1);
      n++;
    end
    cmp_bit(n >= (ticks - 2) * SLOW && n <= ticks * SLOW + 8, 1'b1);
    restore_done = 1'b1;
    wait_mode(M_ACTIVE);
    restore_done = 1'b0;
    wake_ticks = 16'h0000;
    // Power-down: only the host request may end it
    exp_q = {M_OFF};
    pwr_want = 1'b0;
    wait_mode(M_OFF);
    wait_res(SET_NONE);
    cmp_bit(core_rst_n, 1'b0);
    wake_ext = 1'b1;
    step(20);
    wake_ext = 1'b0;
    cmp_mode(mode, M_OFF);
    exp_q = {M_BOOT, M_ACTIVE};
    pwr_want = 1'b1;
    wait_mode(M_ACTIVE);
    cmp_res(res_en, act_set);
    cmp_res(8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule

// [verilog/power_mode_sequencer.sv]
module power_mode_sequencer
  import power_seq_pkg::*;
#(
  parameter int TW = 8,
  parameter int WW = 16
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Pins from outside the clock domain
  input wire logic reg_on_i,
  input wire logic lpo_clk_i,
  input wire logic wake_ext_i,
  input wire logic usb_resume_i,
  // Core-side control
  input wire logic [1:0] mode_req_i,
  input wire logic busy_i,
  input wire logic save_done_i,
  input wire logic restore_done_i,
  // Programmed sequencing tables
  input wire logic [WW-1:0] wake_ticks_i,
  input wire logic [N_RES-1:0] min_res_i,
  input wire logic [N_RES-1:0] act_mask_i,
  input wire logic [N_RES-1:0][N_RES-1:0] dep_i,
  input wire logic [N_RES-1:0][TW-1:0] t_on_i,
  input wire logic [N_RES-1:0][TW-1:0] t_off_i,
  // Power and clock controls
  output logic [N_RES-1:0] res_en_o,
  output logic [2:0] mode_o,
  output logic core_rst_n_o,
  output logic [1:0] clk_sel_o,
  // Retention handshake
  output logic save_req_o,
  output logic restore_req_o,
  // Calibration result
  output logic [CAL_W-1:0] cal_period_o
);

  if (TW < 1 || WW < 2 || N_RES != 8)
  begin : g_bad_param
    $error("power_mode_sequencer: unsupported parameter values");
  end

  typedef struct packed {
    logic [2:0] reg_s;
    logic [2:0] lpo_s;
    logic [2:0] ext_s;
    logic [2:0] usb_s;
    logic reg_lvl;
    logic lpo_lvl;
    logic ext_lvl;
    logic usb_lvl;
    logic tick;
    mode_t mode;
    logic from_deep;
    logic [WW-1:0] wk_tmr;
    logic [CAL_W-1:0] cal_cnt;
    logic [CAL_W-1:0] cal_per;
    logic [N_RES-1:0] en;
    logic core_rst_n;
    logic [1:0] clk_sel;
    logic save_req;
    logic restore_req;
  } seq_t;

  seq_t q;
  seq_t n;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [N_RES-1:0] en_vec;
  logic [N_RES-1:0] busy_vec;
  logic [N_RES-1:0] req_full;
  logic [N_RES-1:0] go_on;
  logic [N_RES-1:0] go_off;
  logic ready;
  logic wake_hit;
  logic kill;

  // A level counts once the second and third stages agree
  function automatic logic filt(input logic [2:0] s, input logic lvl);
    return (s[1] == s[2]) ? s[2] : lvl;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  //////////////////////////////////////////////////////////////////////////
  // One controller per resource, joined through the carrier interface
  res_if #(.TW(TW)) rif [N_RES] ();

  for (genvar i = 0; i < N_RES; i++)
  begin : g_res
    assign rif[i].go_on = go_on[i];
    assign rif[i].go_off = go_off[i];
    assign rif[i].kill = kill;
    assign rif[i].t_on = t_on_i[i];
    assign rif[i].t_off = t_off_i[i];
    assign en_vec[i] = (rif[i].st == RS_ON);
    assign busy_vec[i] = (rif[i].st != RS_OFF);
    res_ctl #(.TW(TW)) u_res (
      .clk_i(mclk_i),
      .rst_n_i(rst_n),
      .tick_i(q.tick),
      .rif(rif[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Required set per mode, closed over the dependency table
  always_comb
  begin
    logic [N_RES-1:0] base;
    base = SET_NONE;
    case (q.mode)
      M_OFF:
        base = SET_NONE;
      M_DOZE:
        base = SET_DOZE | min_res_i;
      M_DEEP:
        base = SET_DEEP;
      default:
        base = act_mask_i | min_res_i | SET_LPL;
    endcase
    req_full = base;
    for (int k = 0; k < N_RES; k++)
    begin
      for (int i = 0; i < N_RES; i++)
      begin
        if (req_full[i])
          req_full = req_full | dep_i[i];
      end
    end
  end

  // Start enable or disable sequences from the dependency table
  always_comb
  begin
    for (int i = 0; i < N_RES; i++)
    begin
      logic dependents;
      dependents = 1'b0;
      for (int j = 0; j < N_RES; j++)
      begin
        if (dep_i[j][i] && busy_vec[j])
          dependents = 1'b1;
      end
      go_on[i] = req_full[i] && !busy_vec[i] &&
        ((dep_i[i] & ~en_vec) == SET_NONE);
      go_off[i] = !req_full[i] && en_vec[i] && !dependents;
    end
  end

  // Only the request pin removes every regulator at once
  assign kill = (q.mode == M_OFF);
  assign ready = ((req_full & ~en_vec) == SET_NONE);
  assign wake_hit = q.ext_lvl || q.usb_lvl ||
    (q.tick && q.wk_tmr == 1);

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole sequencer
  always_comb
  begin
    n = q;
    // Pin synchronisers and agreement filters
    n.reg_s = {q.reg_s[1:0], reg_on_i};
    n.lpo_s = {q.lpo_s[1:0], lpo_clk_i};
    n.ext_s = {q.ext_s[1:0], wake_ext_i};
    n.usb_s = {q.usb_s[1:0], usb_resume_i};
    n.reg_lvl = filt(q.reg_s, q.reg_lvl);
    n.lpo_lvl = filt(q.lpo_s, q.lpo_lvl);
    n.ext_lvl = filt(q.ext_s, q.ext_lvl);
    n.usb_lvl = filt(q.usb_s, q.usb_lvl);
    n.tick = n.lpo_lvl && !q.lpo_lvl;

    // Crystal cycles per slow period; only counted while the crystal runs
    if (!en_vec[RES_XTAL])
      n.cal_cnt = '0;
    else if (q.tick)
    begin
      n.cal_per = q.cal_cnt;
      n.cal_cnt = '0;
    end
    else if (q.cal_cnt != '1)
      n.cal_cnt = q.cal_cnt + 1'b1;
    // Wake timer counts slow ticks while asleep; zero means no timer wake
    if ((q.mode == M_DOZE || q.mode == M_DEEP) && q.tick &&
      q.wk_tmr != '0)
      n.wk_tmr = q.wk_tmr - 1'b1;
    case (q.mode)
      M_OFF:
        if (q.reg_lvl)
          n.mode = M_BOOT;
      M_BOOT:
        if (ready)
          n.mode = M_ACTIVE;
      M_ACTIVE:
        if (mode_req_i == REQ_DOZE)
        begin
          n.mode = M_DOZE;
          n.from_deep = 1'b0;
          n.wk_tmr = wake_ticks_i;
        end
        else if (mode_req_i == REQ_DEEP)
          n.mode = M_SAVE;
      M_SAVE:
        if (save_done_i)
        begin
          n.mode = M_DEEP;
          n.from_deep = 1'b1;
          n.wk_tmr = wake_ticks_i;
        end
      M_DOZE, M_DEEP:
        if (wake_hit)
          n.mode = M_WAKE;
      M_WAKE:
        if (ready)
          n.mode = q.from_deep ? M_RESTORE : M_ACTIVE;
      M_RESTORE:
        if (restore_done_i)
          n.mode = M_ACTIVE;
      default:
        n.mode = M_OFF;
    endcase
    if (!q.reg_lvl)
      n.mode = M_OFF;
    // Registered outputs: enables copy the controller states, the rest follow the next mode
    n.en = en_vec;
    n.save_req = (n.mode == M_SAVE);
    n.restore_req = (n.mode == M_RESTORE);
    // Core reset held in off, boot, deep sleep and a wake from deep sleep
    n.core_rst_n = (n.mode inside {M_ACTIVE, M_SAVE, M_RESTORE, M_DOZE}) ||
      (n.mode == M_WAKE && !n.from_deep);
    // Fast clock only under load; sleep modes and off gate the main clock
    case (n.mode)
      M_ACTIVE:
        n.clk_sel = busy_i ? CLK_FAST : CLK_SLOW;
      M_BOOT, M_WAKE, M_SAVE, M_RESTORE:
        n.clk_sel = CLK_SLOW;
      default:
        n.clk_sel = CLK_GATED;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{mode: M_OFF, default: '0};
    else
      q <= n;
  end

  assign res_en_o = q.en;
  assign mode_o = q.mode;
  assign core_rst_n_o = q.core_rst_n;
  assign clk_sel_o = q.clk_sel;
  assign save_req_o = q.save_req;
  assign restore_req_o = q.restore_req;
  assign cal_period_o = q.cal_per;

  //////////////////////////////////////////////////////////////////////////
  sequence s_off3;
    (q.mode == M_OFF) [*3];
  endsequence
  property p_all_off;
    @(posedge mclk_i) disable iff (!rst_n)
    s_off3 |-> (res_en_o == SET_NONE && !core_rst_n_o);
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("regulators still on with request low");
  property p_off_only_by_pin;
    @(posedge mclk_i) disable iff (!rst_n)
    (q.mode != M_OFF) |-> (q.en[RES_LPL] || $past(q.mode) == M_BOOT ||
      $past(q.mode) == M_OFF || $past(q.mode, 2) == M_OFF);
  endproperty
  a_off_only_by_pin: assert property (p_off_only_by_pin)
    else $error("low-power regulator lost while powered");
  property p_active_rst;
    @(posedge mclk_i) disable iff (!rst_n)
    (mode_o == M_ACTIVE) |-> (core_rst_n_o && clk_sel_o != CLK_GATED);
  endproperty
  a_active_rst: assert property (p_active_rst)
    else $error("active without reset release or clock");
  property p_sleep_gate;
    @(posedge mclk_i) disable iff (!rst_n)
    (mode_o == M_DOZE || mode_o == M_DEEP) |-> clk_sel_o == CLK_GATED;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("main clock running in sleep");
  sequence s_enter_deep;
    (q.mode == M_SAVE && save_done_i && q.reg_lvl) ##1 (q.mode == M_DEEP);
  endsequence
  property p_save_first;
    @(posedge mclk_i) disable iff (!rst_n)
    (q.mode == M_DEEP && $past(q.mode) != M_DEEP) |->
      $past(q.mode) == M_SAVE;
  endproperty
  a_save_first: assert property (p_save_first)
    else $error("deep sleep entered without save");
  property p_deep_entry;
    @(posedge mclk_i) disable iff (!rst_n)
    s_enter_deep |-> (!save_req_o && !core_rst_n_o &&
      clk_sel_o == CLK_GATED);
  endproperty
  a_deep_entry: assert property (p_deep_entry)
    else $error("core not held off on deep sleep entry");
  property p_wake;
    @(posedge mclk_i) disable iff (!rst_n)
    (q.mode == M_DEEP && wake_hit && q.reg_lvl) |=> q.mode == M_WAKE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake event ignored in deep sleep");
  property p_hold_wake;
    @(posedge mclk_i) disable iff (!rst_n)
    (q.mode == M_WAKE && !ready && q.reg_lvl) |=> q.mode == M_WAKE;
  endproperty
  a_hold_wake: assert property (p_hold_wake)
    else $error("left wake before resources ready");
  property p_restore;
    @(posedge mclk_i) disable iff (!rst_n)
    (q.mode == M_WAKE && ready && q.from_deep && q.reg_lvl) |=>
      (q.mode == M_RESTORE && restore_req_o);
  endproperty
  a_restore: assert property (p_restore)
    else $error("deep wake skipped restore");
  property p_deep_set;
    @(posedge mclk_i) disable iff (!rst_n)
    (q.mode == M_DEEP && dep_i[RES_LPL] == SET_NONE) |->
      !(go_on[RES_CSW] || go_on[RES_CLIN] || go_on[RES_LNL]);
  endproperty
  a_deep_set: assert property (p_deep_set)
    else $error("core regulators started in deep sleep");
endmodule

// [verilog/power_seq_pkg.sv]
package power_seq_pkg;

  // Resource indices in the sequencer tables
  localparam int N_RES = 8;
  localparam int RES_CSW = 0;   // core_switching_regulator
  localparam int RES_CLIN = 1;  // core_linear_regulator
  localparam int RES_LNL = 2;   // low_noise_linear_regulator
  localparam int RES_LPL = 3;   // low_power_linear_regulator
  localparam int RES_XTAL = 4;  // Crystal oscillator and main clocks
  localparam int RES_RADIO = 5;
  localparam int RES_ANALOG = 6;
  localparam int RES_CORE = 7;  // Digital core power switch

  // Resource sets per power mode
  localparam logic [N_RES-1:0] SET_NONE = 8'h00;
  localparam logic [N_RES-1:0] SET_LPL = 8'h08;
  localparam logic [N_RES-1:0] SET_DOZE = 8'h8A;
  localparam logic [N_RES-1:0] SET_DEEP = 8'h08;

  // Per-resource state, gray ordered
  typedef enum logic [1:0] {
    RS_OFF = 2'b00,
    RS_TON = 2'b01,
    RS_ON = 2'b11,
    RS_TOFF = 2'b10
  } res_state_t;

  // Chip power modes
  typedef enum logic [2:0] {
    M_OFF = 3'b000,
    M_BOOT = 3'b001,
    M_ACTIVE = 3'b010,
    M_DOZE = 3'b011,
    M_SAVE = 3'b100,
    M_DEEP = 3'b101,
    M_WAKE = 3'b110,
    M_RESTORE = 3'b111
  } mode_t;

  // Software mode requests
  localparam logic [1:0] REQ_ACTIVE = 2'h0;
  localparam logic [1:0] REQ_DOZE = 2'h1;
  localparam logic [1:0] REQ_DEEP = 2'h2;

  // Clock speed selection
  localparam logic [1:0] CLK_GATED = 2'h0;
  localparam logic [1:0] CLK_SLOW = 2'h1;
  localparam logic [1:0] CLK_FAST = 2'h2;

  // Clock rates and the nominal calibration count
  localparam int MCLK_HZ = 25000000;
  localparam int LPO_HZ = 32768;
  localparam int LPO_CYC = MCLK_HZ / LPO_HZ;
  localparam int CAL_W = 12;

endpackage

// [verilog/res_ctl.sv]
module res_ctl
  import power_seq_pkg::*;
#(
  parameter int TW = 8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Low-power oscillator tick
  input wire logic tick_i,
  // Sequencer side
  res_if.ctl rif
);

  typedef struct packed {
    res_state_t st;
    logic [TW-1:0] tmr;
  } ctl_t;

  ctl_t q;
  ctl_t n;

  assign rif.st = q.st;

  // Resource state walk; kill beats everything so power-off is immediate
  always_comb
  begin
    n = q;
    case (q.st)
      RS_OFF:
        if (rif.go_on)
        begin
          if (rif.t_on == '0)
            n.st = RS_ON;
          else
          begin
            n.st = RS_TON;
            n.tmr = rif.t_on;
          end
        end
      RS_ON:
        if (rif.go_off)
        begin
          if (rif.t_off == '0)
            n.st = RS_OFF;
          else
          begin
            n.st = RS_TOFF;
            n.tmr = rif.t_off;
          end
        end
      RS_TON, RS_TOFF:
        if (tick_i)
        begin
          n.tmr = q.tmr - 1'b1;
          if (q.tmr == 1)
            n.st = (q.st == RS_TON) ? RS_ON : RS_OFF;
        end
      default:
        n.st = RS_OFF;
    endcase
    if (rif.kill)
    begin
      n.st = RS_OFF;
      n.tmr = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '{st: RS_OFF, tmr: '0};
    else
      q <= n;
  end

  //////////////////////////////////////////////////////////////////////////

  property p_zero_time;
    @(posedge clk_i) disable iff (!rst_n_i)
    (q.st == RS_OFF && rif.go_on && rif.t_on == '0 && !rif.kill)
      |=> q.st == RS_ON;
  endproperty
  a_zero_time: assert property (p_zero_time)
    else $error("zero on time did not enable at once");

  property p_load;
    @(posedge clk_i) disable iff (!rst_n_i)
    (q.st == RS_OFF && rif.go_on && rif.t_on != '0 && !rif.kill)
      |=> (q.st == RS_TON && q.tmr == $past(rif.t_on));
  endproperty
  a_load: assert property (p_load)
    else $error("timer not loaded with on time");

  property p_finish;
    @(posedge clk_i) disable iff (!rst_n_i)
    (q.st == RS_TON && tick_i && q.tmr == 1 && !rif.kill)
      |=> q.st == RS_ON;
  endproperty
  a_finish: assert property (p_finish)
    else $error("transition did not end at zero");

  property p_kill;
    @(posedge clk_i) disable iff (!rst_n_i)
    rif.kill |=> q.st == RS_OFF;
  endproperty
  a_kill: assert property (p_kill)
    else $error("kill did not disable resource");

endmodule

// [verilog/res_if.sv]
interface res_if
  import power_seq_pkg::*;
#(
  parameter int TW = 8
);
  logic go_on;
  logic go_off;
  logic kill;
  logic [TW-1:0] t_on;
  logic [TW-1:0] t_off;
  res_state_t st;

  modport seq (output go_on, output go_off, output kill, output t_on,
    output t_off, input st);
  modport ctl (input go_on, input go_off, input kill, input t_on,
    input t_off, output st);
endinterface
